// [tci_pkg.sv]
package tci_pkg;

    // Oscillator and counting rate
    localparam int OSC_HZ = 14_318_180;
    localparam int OSC_DIV = 12;
    localparam int COUNTER_PERIOD_NS = 838;
    localparam int CLK_HZ = 20_000_000;

    // I/O offsets of the register port
    localparam logic [7:0] ADDR_COUNT0 = 8'h40;
    localparam logic [7:0] ADDR_COUNT1 = 8'h41;
    localparam logic [7:0] ADDR_COUNT2 = 8'h42;
    localparam logic [7:0] ADDR_CONTROL = 8'h43;
    localparam logic [7:0] ADDR_SPEAKER = 8'h61;
    localparam logic [7:0] ADDR_ROUTE = 8'h50;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h52;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h53;

    // Control word fields
    localparam int CW_SEL_LSB = 6;
    localparam int CW_ACCESS_LSB = 4;
    localparam int CW_MODE_LSB = 1;
    localparam logic [1:0] ACCESS_LATCH = 2'h0;
    localparam logic [1:0] ACCESS_LOW = 2'h1;
    localparam logic [1:0] ACCESS_HIGH = 2'h2;
    localparam logic [1:0] ACCESS_BOTH = 2'h3;
    localparam logic [1:0] SEL_READBACK = 2'h3;

    // Speaker port fields
    localparam int SPK_GATE_BIT = 0;
    localparam int SPK_ENABLE_BIT = 1;
    localparam int SPK_OUT_BIT = 5;

    // Routing register field
    localparam int ROUTE_SYSTEM_TIMER_INTERRUPT_EN_BIT = 7;

    // Reset values
    localparam logic [1:0] ACCESS_RESET = 2'h3;
    localparam logic [2:0] MODE_RESET = 3'h3;
    localparam logic [7:0] SPEAKER_RESET = 8'h00;
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] init;
        logic [15:0] latch;
        logic [7:0] low_byte;
        logic [1:0] access;
        logic [2:0] mode;
        logic out;
        logic pending;
        logic running;
        logic latched;
        logic wr_msb;
        logic rd_msb;
    } tci_cnt_t;

    typedef struct packed {
        tci_cnt_t [2:0] cnt;
        logic [3:0] div;
        logic [7:0] speaker;
        logic [7:0] route;
        logic [2:0] status;
        logic [2:0] mask;
        logic [7:0] rdata;
    } tci_state_t;

endpackage : tci_pkg

// [tci_timer.sv]
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Three independent counters, all counting from the oscillator input.
// - Counter 0 output drives the system timer interrupt line.
// - Square wave of counter 0 has period of initial count, rounded down to even, times counter period.
// - A written count is loaded into the counter at the next tick.
// - Counter 0 starts high, decrements by two, drops output at zero, reloads.
// - At each zero counter 0 reloads and inverts its output.
// - Counter 1 drops refresh request one period at count one, then continues.
// - Counter 2 tone frequency is counting rate divided by initial count rounded down to even.
// - Tone reaches the speaker only after software enables it at port 061h.
// - With routing enable set, board pin carries the counter 0 interrupt.
module tci_timer #(
    parameter int DIV = tci_pkg::OSC_DIV
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic oscillator_clock_input_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic system_timer_interrupt_o,
    output logic refresh_request_o,
    output logic speaker_o,
    output logic board_interrupt_pin_zero_o,
    output logic board_interrupt_pin_zero_oe_o,
    output logic irq_o
);

    if (DIV < 2 || DIV > 16) begin : g_div_check
        $error("tci_timer: DIV must lie between 2 and 16");
    end

    // The byte-wide port must hold every control word field
    if (tci_pkg::CW_SEL_LSB > 6 || tci_pkg::CW_ACCESS_LSB > 6 ||
        tci_pkg::CW_MODE_LSB > 5) begin : g_field_check
        $error("tci_timer: control word field out of range");
    end

    // Counter data ports and the control word must decode apart
    if (tci_pkg::ADDR_COUNT0 == tci_pkg::ADDR_COUNT1 ||
        tci_pkg::ADDR_COUNT1 == tci_pkg::ADDR_COUNT2 ||
        tci_pkg::ADDR_COUNT2 == tci_pkg::ADDR_CONTROL) begin : g_addr_check
        $error("tci_timer: counter addresses overlap");
    end

    localparam logic [3:0] DIV_LAST = 4'(DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // Mode decoding

    function automatic logic is_rate(input logic [2:0] mode);
        return mode[1:0] == 2'b10;
    endfunction : is_rate

    function automatic logic is_square(input logic [2:0] mode);
        return mode[1:0] == 2'b11;
    endfunction : is_square

    ////////////////////////////////////////////////////////////////////////
    // Counter helpers

    // Square counts run on even values only
    function automatic logic [15:0] square_load(input logic [15:0] init);
        return {init[15:1], 1'b0};
    endfunction : square_load

    // One counter period of a counter: load, count and output
    function automatic tci_pkg::tci_cnt_t next_cnt(input tci_pkg::tci_cnt_t c,
        input logic gated);
        tci_pkg::tci_cnt_t n;
        n = c;
        if (c.pending) begin
            n.pending = 1'b0;
            n.running = 1'b1;
            n.count = is_square(c.mode) ? square_load(c.init) : c.init;
            n.out = is_rate(c.mode) || is_square(c.mode);
        end else if (c.running && gated) begin
            if (is_square(c.mode)) begin
                if (c.count == 16'h0002) begin
                    n.count = square_load(c.init);
                    n.out = !c.out;
                end else begin
                    n.count = c.count - 16'h0002;
                end
            end else if (is_rate(c.mode)) begin
                if (c.count == 16'h0001) begin
                    n.count = c.init;
                    n.out = 1'b1;
                end else begin
                    n.count = c.count - 16'h0001;
                    if (c.count == 16'h0002) begin
                        n.out = 1'b0;
                    end
                end
            end else begin
                n.count = c.count - 16'h0001;
                if (c.count == 16'h0001 && !c.out) begin
                    n.out = 1'b1;
                end
            end
        end
        return n;
    endfunction : next_cnt

    // Status event raised by a counting step
    function automatic logic cnt_event(input tci_pkg::tci_cnt_t c, input logic gated);
        if (c.pending || !c.running || !gated) begin
            return 1'b0;
        end else if (is_square(c.mode) || is_rate(c.mode)) begin
            return c.count == 16'h0002;
        end else begin
            return c.count == 16'h0001 && !c.out;
        end
    endfunction : cnt_event

    // Control word: latch command, or new access and mode for one counter
    function automatic tci_pkg::tci_cnt_t apply_control(input tci_pkg::tci_cnt_t c,
        input logic [15:0] now, input logic [7:0] cw);
        tci_pkg::tci_cnt_t n;
        n = c;
        if (cw[tci_pkg::CW_ACCESS_LSB +: 2] == tci_pkg::ACCESS_LATCH) begin
            if (!c.latched) begin
                n.latch = now;
                n.latched = 1'b1;
            end
        end else begin
            n.access = cw[tci_pkg::CW_ACCESS_LSB +: 2];
            n.mode = cw[tci_pkg::CW_MODE_LSB +: 3];
            n.out = cw[tci_pkg::CW_MODE_LSB +: 3] != 3'h0;
            n.running = 1'b0;
            n.pending = 1'b0;
            n.latched = 1'b0;
            n.wr_msb = 1'b0;
            n.rd_msb = 1'b0;
        end
        return n;
    endfunction : apply_control

    // Count byte written by software; the counter takes it at the next tick
    function automatic tci_pkg::tci_cnt_t load_count(input tci_pkg::tci_cnt_t c,
        input logic [7:0] data);
        tci_pkg::tci_cnt_t n;
        n = c;
        if (c.access == tci_pkg::ACCESS_LOW) begin
            n.init = {8'h00, data};
            n.pending = 1'b1;
        end else if (c.access == tci_pkg::ACCESS_HIGH) begin
            n.init = {data, 8'h00};
            n.pending = 1'b1;
        end else if (!c.wr_msb) begin
            n.low_byte = data;
            n.wr_msb = 1'b1;
        end else begin
            n.init = {data, c.low_byte};
            n.wr_msb = 1'b0;
            n.pending = 1'b1;
        end
        if (c.mode == 3'h0) begin
            n.out = 1'b0;
        end
        return n;
    endfunction : load_count

    // Read value of the registers other than the counters
    function automatic logic [7:0] misc_read(input logic [7:0] addr,
        input tci_pkg::tci_state_t s);
        logic [7:0] v;
        v = 8'h00;
        if (addr == tci_pkg::ADDR_SPEAKER) begin
            v = s.speaker;
            v[tci_pkg::SPK_OUT_BIT] = s.cnt[2].out;
        end else if (addr == tci_pkg::ADDR_ROUTE) begin
            v = s.route;
        end else if (addr == tci_pkg::ADDR_IRQ_STATUS) begin
            v = {5'h00, s.status};
        end else if (addr == tci_pkg::ADDR_IRQ_MASK) begin
            v = {5'h00, s.mask};
        end
        return v;
    endfunction : misc_read

    function automatic logic [7:0] read_byte(input tci_pkg::tci_cnt_t c);
        logic [15:0] v;
        v = c.latched ? c.latch : c.count;
        if (c.access == tci_pkg::ACCESS_HIGH) begin
            return v[15:8];
        end else if (c.access == tci_pkg::ACCESS_BOTH && c.rd_msb) begin
            return v[15:8];
        end else begin
            return v[7:0];
        end
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////
    // State

    tci_pkg::tci_state_t q;
    tci_pkg::tci_state_t d;

    logic tick;
    wire logic [2:0] event_set;
    wire tci_pkg::tci_cnt_t [2:0] stepped;
    logic [2:0] gate;
    logic [1:0] sel;
    logic [1:0] idx;
    logic data_wr;
    logic data_rd;

    assign tick = oscillator_clock_input_i && q.div == DIV_LAST;
    assign gate = {q.speaker[tci_pkg::SPK_GATE_BIT], 2'b11};
    assign sel = wdata_i[tci_pkg::CW_SEL_LSB +: 2];

    // Each counter steps once per counter period, counter 2 only while its gate bit is set
    for (genvar i = 0; i < 3; i++) begin : g_cnt
        assign stepped[i] = tick ? next_cnt(q.cnt[i], gate[i]) : q.cnt[i];
        assign event_set[i] = tick && cnt_event(q.cnt[i], gate[i]);
    end

    always_comb begin
        d = q;
        idx = 2'h0;
        data_wr = 1'b0;
        data_rd = 1'b0;

        // Oscillator prescaler
        if (oscillator_clock_input_i) begin
            d.div = (q.div == DIV_LAST) ? 4'h0 : q.div + 4'h1;
        end

        // Counting, one step per counter period
        d.cnt = stepped;

        // Register writes
        if (wr_i) begin
            if (addr_i == tci_pkg::ADDR_CONTROL) begin
                if (sel != tci_pkg::SEL_READBACK) begin
                    idx = sel;
                    d.cnt[idx] = apply_control(d.cnt[idx], q.cnt[idx].count, wdata_i);
                end
            end else if (addr_i == tci_pkg::ADDR_COUNT0) begin
                idx = 2'h0;
                data_wr = 1'b1;
            end else if (addr_i == tci_pkg::ADDR_COUNT1) begin
                idx = 2'h1;
                data_wr = 1'b1;
            end else if (addr_i == tci_pkg::ADDR_COUNT2) begin
                idx = 2'h2;
                data_wr = 1'b1;
            end else if (addr_i == tci_pkg::ADDR_SPEAKER) begin
                d.speaker = {6'h00, wdata_i[1:0]};
            end else if (addr_i == tci_pkg::ADDR_ROUTE) begin
                d.route = {wdata_i[tci_pkg::ROUTE_SYSTEM_TIMER_INTERRUPT_EN_BIT], 7'h00};
            end else if (addr_i == tci_pkg::ADDR_IRQ_MASK) begin
                d.mask = wdata_i[2:0];
            end
        end

        // Count loading: the new value takes effect at the next tick
        if (data_wr) begin
            d.cnt[idx] = load_count(d.cnt[idx], wdata_i);
        end

        // Register reads, answered one cycle later
        d.rdata = 8'h00;
        if (rd_i) begin
            if (addr_i == tci_pkg::ADDR_COUNT0) begin
                idx = 2'h0;
                data_rd = 1'b1;
            end else if (addr_i == tci_pkg::ADDR_COUNT1) begin
                idx = 2'h1;
                data_rd = 1'b1;
            end else if (addr_i == tci_pkg::ADDR_COUNT2) begin
                idx = 2'h2;
                data_rd = 1'b1;
            end else begin
                d.rdata = misc_read(addr_i, q);
            end
        end

        if (data_rd) begin
            d.rdata = read_byte(q.cnt[idx]);
            if (q.cnt[idx].access == tci_pkg::ACCESS_BOTH && !q.cnt[idx].rd_msb) begin
                d.cnt[idx].rd_msb = 1'b1;
            end else begin
                d.cnt[idx].rd_msb = 1'b0;
                d.cnt[idx].latched = 1'b0;
            end
        end

        // Sticky events: a set in the clearing cycle wins
        if (wr_i && addr_i == tci_pkg::ADDR_IRQ_STATUS) begin
            d.status = q.status & ~wdata_i[2:0];
        end
        d.status = d.status | event_set;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            for (int i = 0; i < 3; i++) begin
                q.cnt[i].access <= tci_pkg::ACCESS_RESET;
                q.cnt[i].mode <= tci_pkg::MODE_RESET;
                q.cnt[i].out <= 1'b1;
            end
            q.speaker <= tci_pkg::SPEAKER_RESET;
            q.route <= tci_pkg::ROUTE_RESET;
            q.mask <= tci_pkg::IRQ_MASK_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_o = q.rdata;
    assign system_timer_interrupt_o = q.cnt[0].out;
    assign refresh_request_o = q.cnt[1].out;
    assign speaker_o = q.cnt[2].out && q.speaker[tci_pkg::SPK_ENABLE_BIT];
    assign board_interrupt_pin_zero_oe_o = q.route[tci_pkg::ROUTE_SYSTEM_TIMER_INTERRUPT_EN_BIT];
    assign board_interrupt_pin_zero_o = q.route[tci_pkg::ROUTE_SYSTEM_TIMER_INTERRUPT_EN_BIT] &&
        q.cnt[0].out;
    assign irq_o = |(q.status & q.mask);

endmodule : tci_timer

`default_nettype wire

// [tci_checker.sv]
`timescale 1ns/1ns
`default_nettype none

module tci_checker #(
    parameter int DIV = 12
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic oscillator_clock_input_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic system_timer_interrupt_o,
    input wire logic refresh_request_o,
    input wire logic board_interrupt_pin_zero_o,
    input wire logic board_interrupt_pin_zero_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Oscillator beats seen while the refresh request is low
    int low_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_q <= 0;
        end else if (refresh_request_o) begin
            low_q <= 0;
        end else if (oscillator_clock_input_i) begin
            low_q <= low_q + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_refresh_one_tick: assert property (
        $rose(refresh_request_o) |-> low_q == DIV) else $error("refresh low width wrong");
    a_refresh_back_high: assert property (
        $rose(refresh_request_o) |=> refresh_request_o) else $error("refresh dropped again");
    a_timer_half_wave: assert property (
        $changed(system_timer_interrupt_o) |=> $stable(system_timer_interrupt_o))
        else $error("timer toggled too soon");
    a_pin_tracks_timer: assert property (
        board_interrupt_pin_zero_oe_o |-> board_interrupt_pin_zero_o == system_timer_interrupt_o)
        else $error("board pin differs from timer");
    a_pin_quiet_off: assert property (
        !board_interrupt_pin_zero_oe_o |-> !board_interrupt_pin_zero_o)
        else $error("board pin driven while off");
    a_oe_by_write: assert property (
        $changed(board_interrupt_pin_zero_oe_o) |-> $past(wr_i) || $past(wr_i, 2))
        else $error("pin enable changed without write");
    a_rdata_one_cycle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read slot");
    a_rdata_unmapped: assert property (
        $past(rd_i) && !($past(addr_i) inside {[8'h40:8'h43], 8'h50, 8'h52, 8'h53, 8'h61})
        |-> rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule : tci_checker

bind tci_timer tci_checker #(.DIV(DIV)) tci_checker_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .oscillator_clock_input_i(oscillator_clock_input_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .system_timer_interrupt_o(system_timer_interrupt_o),
    .refresh_request_o(refresh_request_o),
    .board_interrupt_pin_zero_o(board_interrupt_pin_zero_o),
    .board_interrupt_pin_zero_oe_o(board_interrupt_pin_zero_oe_o)
);

`default_nettype wire

// [tci_partner.sv]
`timescale 1ns/1ns
`default_nettype none

module tci_partner (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic osc_o,
    output int edges_o
);
    logic pin_q;

    // Oscillator beat held on outside reset
    assign osc_o = rst_n_i;

    // External controller input zero counts rising edges
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= 1'b0;
            edges_o <= 0;
        end else begin
            pin_q <= pin_i;
            if (oe_i && pin_i && !pin_q) begin
                edges_o <= edges_o + 1;
            end
        end
    end
endmodule : tci_partner

`default_nettype wire

// [test_three_channel_interval_timer.sv]
`timescale 1ns/1ns
`default_nettype none

module test_three_channel_interval_timer;
    localparam int DIV = 2;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic tmr, rfr, spk, pin, oe, irq, osc;
    logic [2:0] outs;
    logic [7:0] exp_q[$];
    int edges, e0, n, m, k, g;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    assign outs = {spk, rfr, tmr};
    always #25 clock_i = ~clock_i;

    tci_timer #(.DIV(DIV)) tci_timer_i (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .oscillator_clock_input_i(osc),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .system_timer_interrupt_o(tmr),
        .refresh_request_o(rfr),
        .speaker_o(spk),
        .board_interrupt_pin_zero_o(pin),
        .board_interrupt_pin_zero_oe_o(oe),
        .irq_o(irq)
    );

    tci_partner tci_partner_i (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .pin_i(pin),
        .oe_i(oe),
        .osc_o(osc),
        .edges_o(edges)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask : rd

    // Control word, then low and high count bytes
    task automatic load(input logic [7:0] cw, input int cnt);
        wr(8'h43, cw);
        wr({6'h10, cw[7:6]}, cnt[7:0]);
        wr({6'h10, cw[7:6]}, cnt[15:8]);
    endtask : load

    // Cycles from one rising edge of an output to the next
    task automatic gap(input int s, output int c);
        logic p;
        repeat (2) begin
            c = 0;
            do begin
                p = outs[s];
                @(negedge clock_i);
                c++;
            end while (!(outs[s] && !p) && c < 5000);
        end
    endtask : gap

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            stop_test();
        end
        if (rd_q) begin
            check(rdata_o === exp_q.pop_front(), "read data");
        end
        rd_q <= rd_i;
    end

    initial begin
        n = $urandom(32'hcc10d996);
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(8'h50, 8'h00);
        rd(8'h53, 8'h00);
        rd(8'h7f, 8'h00);
        check(tmr === 1'b1, "timer not high at start");
        n = 2 * $urandom_range(20, 2);
        load(8'h36, n);
        gap(0, g);
        check(g == n * DIV, "timer period");
        m = $urandom_range(30, 3);
        load(8'h74, m);
        gap(1, g);
        check(g == m * DIV, "refresh period");
        k = 2 * $urandom_range(20, 2);
        wr(8'h61, 8'h01);
        load(8'hb6, k);
        repeat (2 * k * DIV) begin
            @(negedge clock_i);
            check(spk === 1'b0, "speaker before enable");
        end
        wr(8'h61, 8'h03);
        gap(2, g);
        check(g == k * DIV, "tone period");
        wr(8'h50, 8'h80);
        rd(8'h50, 8'h80);
        e0 = edges;
        gap(0, g);
        check(edges > e0 && oe === 1'b1, "board pin edges");
        wr(8'h53, 8'h01);
        gap(0, g);
        repeat (2) @(negedge clock_i);
        check(irq === 1'b1, "interrupt not raised");
        wr(8'h53, 8'h00);
        wr(8'h52, 8'h07);
        repeat (2) @(negedge clock_i);
        check(irq === 1'b0, "interrupt not masked");
        stop_test();
    end
endmodule : test_three_channel_interval_timer

`default_nettype wire
